// file: core/crm_register_model.sv
// Overview of operation
// RL1: user mode sees sixteen 32-bit general registers.
// RL2: a 32-bit program counter sits beside the general registers.
// RL3: data registers take byte, word and long-word writes.
// RL4: address registers and user stack pointer serve as stack and base pointers.
// RL5: address registers take word and long writes, never byte.
// RL6: any of the sixteen registers can be an index register.
// RL7: flag byte records overflow, zero, negative, carry and extend.
// RL8: flag byte is the low status byte, reachable in both modes.
// RL9: supervisor alone reaches high status byte and supervisor stack pointer.
// RL10: high status byte holds a three-bit mask of eight levels.
// RL11: status register shows trace mode and supervisor mode.
// RL12: privileged operations are allowed only in supervisor mode.
// RL13: twos-complement bit, BCD, byte, word and long operands.
// RL14: operand size comes from instruction field or is implied.
// RL15: 32-bit registers move over a 16-bit path; addresses are 32-bit.
// RL16: register seven picks user or supervisor stack pointer by mode.
`timescale 1ns/1ns
`default_nettype none
module crm_register_model (
  input  wire logic                clock,
  input  wire logic                sys_rst,
  input  wire crm_pkg::crm_wr_s    wr,
  input  wire logic [1:0]          size_field,
  input  wire crm_pkg::crm_size_e  size_implied,
  input  wire logic                use_implied,
  input  wire logic                ext_wr_en,
  input  wire logic                ext_hi,
  input  wire logic [3:0]          ext_sel,
  input  wire logic [15:0]         ext_wdata,
  output logic [15:0]              ext_rdata,
  input  wire logic [3:0]          rd_sel,
  input  wire logic [4:0]          bit_num,
  output logic [31:0]              rd_data,
  output logic                     rd_bit,
  input  wire crm_pkg::crm_ea_s    ea_req,
  output logic [31:0]              ea_addr,
  output logic                     ea_valid,
  input  wire logic                flags_we,
  input  wire crm_pkg::crm_flags_s flags_in,
  input  wire logic                sr_wr_en,
  input  wire logic [15:0]         sr_wdata,
  input  wire logic                user_stack_ptr_wr_en,
  input  wire logic [31:0]         user_stack_ptr_wdata,
  output logic [31:0]              user_stack_ptr_rdata,
  input  wire logic                priv_op,
  input  wire logic                pc_load,
  input  wire logic [31:0]         pc_wdata,
  input  wire logic                pc_step,
  output logic [31:0]              pc,
  output logic [15:0]              sr,
  output logic                     supervisor,
  output logic                     trace,
  output logic [2:0]               int_mask,
  output logic                     priv_fault,
  output logic                     size_fault
);

  // ==========================================================
  // storage
  // ==========================================================
  logic [31:0]        dreg_q [crm_pkg::NUM_DREG];
  logic [31:0]        areg_q [crm_pkg::NUM_AREG];
  logic [31:0]        user_stack_ptr_q;
  logic [31:0]        supervisor_stack_ptr_q;
  logic [31:0]        pc_q;
  logic [15:0]        sr_q;
  logic               super_w;
  crm_pkg::crm_size_e size_w;
  logic               wr_dreg;
  logic               wr_areg;
  logic               area_ok;
  assign super_w = sr_q[crm_pkg::SR_S];

  // ==========================================================
  // helpers
  // ==========================================================
  // size field of an instruction to operand format
  function automatic crm_pkg::crm_size_e size_decode(
    input logic [1:0] fld
  );
    unique case (fld)
      crm_pkg::FLD_BYTE: size_decode = crm_pkg::SZ_BYTE;
      crm_pkg::FLD_WORD: size_decode = crm_pkg::SZ_WORD;
      default:           size_decode = crm_pkg::SZ_LONG;
    endcase
  endfunction : size_decode
  // sizes narrower than a word
  function automatic logic is_narrow(
    input crm_pkg::crm_size_e sz
  );
    is_narrow = (sz == crm_pkg::SZ_BIT) || (sz == crm_pkg::SZ_BCD)
             || (sz == crm_pkg::SZ_BYTE);
  endfunction : is_narrow
  // merge a sized result into a data register
  function automatic logic [31:0] merge(
    input logic [31:0]        old_v,
    input logic [31:0]        new_v,
    input crm_pkg::crm_size_e sz
  );
    if (sz == crm_pkg::SZ_LONG) begin
      merge = new_v;
    end else if (sz == crm_pkg::SZ_WORD) begin
      merge = {old_v[31:16], new_v[15:0]};
    end else begin
      merge = {old_v[31:8], new_v[7:0]};
    end
  endfunction : merge

  // read any of the sixteen registers; seven follows the mode
  function automatic logic [31:0] reg_read(
    input logic [3:0] sel
  );
    if (!sel[3]) begin
      reg_read = dreg_q[sel[2:0]];
    end else if (sel[2:0] == 3'h7) begin
      reg_read = super_w ? supervisor_stack_ptr_q : user_stack_ptr_q; // [RL16]
    end else begin
      reg_read = areg_q[sel[2:0]];
    end
  endfunction : reg_read

  // ==========================================================
  // operand size selection
  // ==========================================================
  // implied size wins when the operation fixes it
  assign size_w  = use_implied ? size_implied
                               : size_decode(size_field); // [RL14]
  assign wr_dreg = wr.en && !wr.sel[3];
  assign wr_areg = wr.en && wr.sel[3];
  assign area_ok = !is_narrow(size_w); // [RL5]

  // ==========================================================
  // data registers
  // ==========================================================
  // sized core writes, then 16-bit halves from the external path
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      for (int i = 0; i < crm_pkg::NUM_DREG; i++) begin
        dreg_q[i] <= 32'h0000_0000;
      end
    end else begin
      if (wr_dreg) begin
        dreg_q[wr.sel[2:0]] <= merge(dreg_q[wr.sel[2:0]],
                                     wr.data, size_w); // [RL3] [RL13]
      end
      if (ext_wr_en && !ext_sel[3]) begin
        if (ext_hi) begin
          dreg_q[ext_sel[2:0]][31:16] <= ext_wdata; // [RL15]
        end else begin
          dreg_q[ext_sel[2:0]][15:0] <= ext_wdata; // [RL15]
        end
      end
    end
  end

  // ==========================================================
  // address registers zero to six
  // ==========================================================
  // word writes sign-extend to the full pointer
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      for (int i = 0; i < crm_pkg::NUM_AREG; i++) begin
        areg_q[i] <= 32'h0000_0000;
      end
    end else begin
      if (wr_areg && area_ok && wr.sel[2:0] != 3'h7) begin
        areg_q[wr.sel[2:0]] <= (size_w == crm_pkg::SZ_WORD)
          ? {{16{wr.data[15]}}, wr.data[15:0]}
          : wr.data; // [RL4] [RL5]
      end
      if (ext_wr_en && ext_sel[3] && ext_sel[2:0] != 3'h7) begin
        if (ext_hi) begin
          areg_q[ext_sel[2:0]][31:16] <= ext_wdata;
        end else begin
          areg_q[ext_sel[2:0]][15:0] <= ext_wdata;
        end
      end
    end
  end

  // ==========================================================
  // stack pointers
  // ==========================================================
  logic        sp7_core;
  logic        sp7_ext;
  logic [31:0] sp7_val;
  assign sp7_core = wr_areg && area_ok && wr.sel[2:0] == 3'h7;
  assign sp7_ext  = ext_wr_en && ext_sel[3] && ext_sel[2:0] == 3'h7;
  assign sp7_val  = (size_w == crm_pkg::SZ_WORD)
                  ? {{16{wr.data[15]}}, wr.data[15:0]} : wr.data;
  // user pointer: register seven in user mode, explicit port in supervisor
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      user_stack_ptr_q <= crm_pkg::SP_RESET;
    end else if (!super_w) begin
      if (sp7_core) begin
        user_stack_ptr_q <= sp7_val; // [RL4] [RL16]
      end
      if (sp7_ext && ext_hi) begin
        user_stack_ptr_q[31:16] <= ext_wdata;
      end else if (sp7_ext) begin
        user_stack_ptr_q[15:0] <= ext_wdata;
      end
    end else if (user_stack_ptr_wr_en) begin
      user_stack_ptr_q <= user_stack_ptr_wdata;
    end
  end

  // supervisor pointer: only reachable while in supervisor mode
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      supervisor_stack_ptr_q <= crm_pkg::SP_RESET;
    end else if (super_w) begin
      if (sp7_core) begin
        supervisor_stack_ptr_q <= sp7_val; // [RL9] [RL16]
      end
      if (sp7_ext && ext_hi) begin
        supervisor_stack_ptr_q[31:16] <= ext_wdata;
      end else if (sp7_ext) begin
        supervisor_stack_ptr_q[15:0] <= ext_wdata;
      end
    end
  end

  // ==========================================================
  // program counter
  // ==========================================================
  // load wins over the word step
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      pc_q <= crm_pkg::PC_RESET;
    end else if (pc_load) begin
      pc_q <= pc_wdata; // [RL2]
    end else if (pc_step) begin
      pc_q <= pc_q + 32'(crm_pkg::PC_STEP);
    end
  end

  // ==========================================================
  // status register
  // ==========================================================
  // flag results first; a move to the register overrides them
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sr_q <= crm_pkg::SR_RESET;
    end else begin
      if (flags_we) begin
        sr_q[crm_pkg::SR_X] <= flags_in.x; // [RL7]
        sr_q[crm_pkg::SR_N] <= flags_in.n;
        sr_q[crm_pkg::SR_Z] <= flags_in.z;
        sr_q[crm_pkg::SR_V] <= flags_in.v;
        sr_q[crm_pkg::SR_C] <= flags_in.c;
      end
      if (sr_wr_en && super_w) begin
        sr_q <= sr_wdata & crm_pkg::SR_IMPL; // [RL9] [RL10] [RL11]
      end else if (sr_wr_en) begin
        sr_q[crm_pkg::FLAGS_HI:0] <= sr_wdata[crm_pkg::FLAGS_HI:0]
          & crm_pkg::SR_IMPL[crm_pkg::FLAGS_HI:0]; // [RL8]
      end
    end
  end

  // ==========================================================
  // faults
  // ==========================================================
  // privileged access from user mode, or a narrow address write
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      priv_fault <= 1'b0;
      size_fault <= 1'b0;
    end else begin
      priv_fault <= !super_w && (priv_op || user_stack_ptr_wr_en
        || (sr_wr_en && sr_wdata[15:8] != sr_q[15:8])); // [RL12] [RL9]
      size_fault <= wr_areg && !area_ok; // [RL5]
    end
  end

  // ==========================================================
  // read ports
  // ==========================================================
  logic [31:0] rd_w;
  logic [31:0] ext_w;
  assign rd_w  = reg_read(rd_sel);
  assign ext_w = reg_read(ext_sel);
  // registered general read, bit test and 16-bit half
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rd_data              <= 32'h0000_0000;
      rd_bit               <= 1'b0;
      ext_rdata            <= 16'h0000;
      user_stack_ptr_rdata <= 32'h0000_0000;
    end else begin
      rd_data              <= rd_w; // [RL1]
      rd_bit               <= rd_w[bit_num]; // [RL13]
      ext_rdata            <= ext_hi ? ext_w[31:16] : ext_w[15:0]; // [RL15]
      user_stack_ptr_rdata <= super_w ? user_stack_ptr_q : 32'h0000_0000; // [RL9]
    end
  end

  // ==========================================================
  // address calculation
  // ==========================================================
  logic [31:0] base_w;
  logic [31:0] idx_raw;
  logic [31:0] idx_w;
  logic [31:0] disp_w;
  assign base_w  = ea_req.pc_rel ? pc_q
                 : reg_read({1'b1, ea_req.base_sel}); // [RL4]
  assign idx_raw = reg_read(ea_req.index_sel); // [RL6]
  assign idx_w   = !ea_req.use_index ? 32'h0000_0000
                 : ea_req.index_long ? idx_raw
                 : {{16{idx_raw[15]}}, idx_raw[15:0]};
  assign disp_w  = {{16{ea_req.disp[15]}}, ea_req.disp};
  // base plus index plus displacement, full 32-bit result
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ea_addr  <= 32'h0000_0000;
      ea_valid <= 1'b0;
    end else begin
      ea_valid <= ea_req.en;
      if (ea_req.en) begin
        ea_addr <= base_w + idx_w + disp_w; // [RL15] [RL6]
      end
    end
  end

  // ==========================================================
  // status outputs
  // ==========================================================
  assign pc         = pc_q;
  assign sr         = sr_q;
  assign supervisor = sr_q[crm_pkg::SR_S]; // [RL11]
  assign trace      = sr_q[crm_pkg::SR_T]; // [RL11]
  assign int_mask   = sr_q[crm_pkg::SR_IM_HI:crm_pkg::SR_IM_LO]; // [RL10]

endmodule : crm_register_model
`default_nettype wire

// file: shared/crm_pkg.sv
`default_nettype none
package crm_pkg;

  // ==========================================================
  // widths and register counts
  // ==========================================================
  localparam int DATA_W     = 32;
  localparam int EXT_W      = 16;
  localparam int NUM_DREG   = 8;
  localparam int NUM_AREG   = 7;
  localparam int PC_STEP    = 2;

  // ==========================================================
  // status register field positions
  // ==========================================================
  localparam int SR_C       = 0;
  localparam int SR_V       = 1;
  localparam int SR_Z       = 2;
  localparam int SR_N       = 3;
  localparam int SR_X       = 4;
  localparam int SR_IM_LO   = 8;
  localparam int SR_IM_HI   = 10;
  localparam int SR_S       = 13;
  localparam int SR_T       = 15;
  localparam int FLAGS_HI   = 7;

  // ==========================================================
  // values after reset and mask of implemented status bits
  // ==========================================================
  localparam logic [15:0] SR_RESET  = 16'h2700;
  localparam logic [15:0] SR_IMPL   = 16'ha71f;
  localparam logic [31:0] PC_RESET  = 32'h0000_0000;
  localparam logic [31:0] SP_RESET  = 32'h0000_0000;

  // ==========================================================
  // operand formats and size field codes
  // ==========================================================
  typedef enum logic [4:0] {
    SZ_BIT  = 5'h01,
    SZ_BCD  = 5'h02,
    SZ_BYTE = 5'h04,
    SZ_WORD = 5'h08,
    SZ_LONG = 5'h10
  } crm_size_e;

  localparam logic [1:0] FLD_BYTE = 2'h0;
  localparam logic [1:0] FLD_WORD = 2'h1;
  localparam logic [1:0] FLD_LONG = 2'h2;

  // ==========================================================
  // carriers
  // ==========================================================
  typedef struct packed {
    logic        en;
    logic [3:0]  sel;
    logic [31:0] data;
  } crm_wr_s;

  typedef struct packed {
    logic        x;
    logic        n;
    logic        z;
    logic        v;
    logic        c;
  } crm_flags_s;

  typedef struct packed {
    logic        en;
    logic        pc_rel;
    logic [2:0]  base_sel;
    logic        use_index;
    logic [3:0]  index_sel;
    logic        index_long;
    logic [15:0] disp;
  } crm_ea_s;

endpackage : crm_pkg
`default_nettype wire

// file: verification/crm_register_model_checker.sv
`timescale 1ns/1ns
`default_nettype none
module crm_register_model_checker (
  input wire logic                clock,
  input wire logic                sys_rst,
  input wire crm_pkg::crm_wr_s    wr,
  input wire logic [1:0]          size_field,
  input wire crm_pkg::crm_size_e  size_implied,
  input wire logic                use_implied,
  input wire crm_pkg::crm_ea_s    ea_req,
  input wire logic [31:0]         ea_addr,
  input wire logic                ea_valid,
  input wire logic                flags_we,
  input wire crm_pkg::crm_flags_s flags_in,
  input wire logic                sr_wr_en,
  input wire logic                user_stack_ptr_wr_en,
  input wire logic [31:0]         user_stack_ptr_rdata,
  input wire logic                priv_op,
  input wire logic                pc_load,
  input wire logic [31:0]         pc_wdata,
  input wire logic                pc_step,
  input wire logic [31:0]         pc,
  input wire logic [15:0]         sr,
  input wire logic                supervisor,
  input wire logic                priv_fault,
  input wire logic                size_fault
);
  // ==========
  // clocking and helpers
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  // byte, bcd or bit sized write aimed at an address register
  wire logic        addr_byte = wr.en && wr.sel[3] &&
    (use_implied ? (size_implied[2:0] != 3'h0) : (size_field == 2'h0));
  wire logic [31:0] disp_x    = {{16{ea_req.disp[15]}}, ea_req.disp};
  // ==========
  // assertions
  chk_pc_step_two: assert property (pc_step && !pc_load |=> pc == $past(pc) + 32'h0000_0002)
    else $error("pc did not advance by two");
  chk_pc_load_value: assert property (pc_load |=> pc == $past(pc_wdata))
    else $error("pc load value lost");
  chk_flags_load: assert property (flags_we && !sr_wr_en |=> sr[4:0] == $past(flags_in))
    else $error("flag byte not loaded");
  chk_user_hi_held: assert property (!supervisor |=> $stable(sr[15:8]))
    else $error("high status byte changed in user mode");
  chk_user_priv_fault: assert property (!supervisor
    && (priv_op || user_stack_ptr_wr_en) |=> priv_fault)
    else $error("privileged use in user mode not flagged");
  chk_super_no_fault: assert property (supervisor |=> !priv_fault)
    else $error("fault raised in supervisor mode");
  chk_addr_byte_refused: assert property (addr_byte |=> size_fault)
    else $error("byte write to address register not refused");
  chk_user_sp_zero: assert property (!supervisor
    |=> user_stack_ptr_rdata == 32'h0000_0000)
    else $error("user stack pointer port open in user mode");
  chk_ea_pc_rel: assert property (ea_req.en && ea_req.pc_rel && !ea_req.use_index |=>
    ea_valid && ea_addr == $past(pc) + $past(disp_x))
    else $error("pc relative address wrong");
  // ==========
  // covers
  cov_priv_fault: cover property (priv_fault);
  cov_size_fault: cover property (size_fault);
  cov_user_mode: cover property (!supervisor ##1 priv_fault);
endmodule : crm_register_model_checker
bind crm_register_model crm_register_model_checker u_checker (.clock, .sys_rst, .wr, .size_field,
  .size_implied, .use_implied, .ea_req, .ea_addr, .ea_valid, .flags_we, .flags_in, .sr_wr_en,
  .user_stack_ptr_wr_en, .user_stack_ptr_rdata, .priv_op, .pc_load, .pc_wdata, .pc_step, .pc,
  .sr, .supervisor, .priv_fault, .size_fault);
`default_nettype wire

// file: verification/test_cpu_core_register_model.sv
`timescale 1ns/1ns
`default_nettype none
module test_cpu_core_register_model;
  // ==========
  // design signals and bench state
  logic                clock, sys_rst, use_implied, ext_wr_en, ext_hi, flags_we, sr_wr_en;
  logic                user_stack_ptr_wr_en, priv_op, pc_load, pc_step, rd_bit, ea_valid;
  logic                supervisor, trace, priv_fault, size_fault, exp_sf;
  logic [1:0]          size_field, sz;
  logic [2:0]          int_mask;
  logic [3:0]          ext_sel, rd_sel;
  logic [4:0]          bit_num;
  logic [15:0]         ext_wdata, ext_rdata, sr_wdata, sr;
  logic [31:0]         rd_data, ea_addr, pc_wdata, pc, exp_rd;
  logic [31:0]         user_stack_ptr_wdata, user_stack_ptr_rdata;
  logic [31:0]         rf [16];
  crm_pkg::crm_wr_s    wr;
  crm_pkg::crm_size_e  size_implied;
  crm_pkg::crm_ea_s    ea_req;
  crm_pkg::crm_flags_s flags_in;
  int                  errors, checked, cycles, seed, i;

  crm_register_model DUT (.clock, .sys_rst, .wr, .size_field, .size_implied, .use_implied,
    .ext_wr_en, .ext_hi, .ext_sel, .ext_wdata, .ext_rdata, .rd_sel, .bit_num, .rd_data, .rd_bit,
    .ea_req, .ea_addr, .ea_valid, .flags_we, .flags_in, .sr_wr_en, .sr_wdata,
    .user_stack_ptr_wr_en, .user_stack_ptr_wdata, .user_stack_ptr_rdata, .priv_op, .pc_load,
    .pc_wdata, .pc_step, .pc, .sr, .supervisor, .trace, .int_mask, .priv_fault, .size_fault);

  // clock of 8 ns
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  // hang guard
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      wrap_up();
    end
  end

  // ==========
  // tasks and expectation helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wrap_up();
    if (errors == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up

  task automatic tick();
    @(posedge clock);
    @(negedge clock);
  endtask : tick

  task automatic wreg(input logic [3:0] s, input logic [31:0] d);
    wr = '{1'b1, s, d};
    size_field = 2'h2;
    use_implied = 1'b0;
    tick();
    wr.en = 1'b0;
  endtask : wreg

  task automatic rst_chk(input int n);
    sys_rst = 1'b1;
    repeat (n) tick();
    sys_rst = 1'b0;
    check(sr, 16'h2700);
    check(pc, 32'h0000_0000);
    check(supervisor, 1'b1);
  endtask : rst_chk

  // register after a core write; sz 0 byte, 1 word, 2 long
  function automatic logic [31:0] merged(input logic [31:0] old, input logic [31:0] d,
                                         input logic is_addr, input logic [1:0] s);
    if (s == 2'h2) return d;
    if (is_addr) return (s == 2'h1) ? {{16{d[15]}}, d[15:0]} : old;
    return (s == 2'h1) ? {old[31:16], d[15:0]} : {old[31:8], d[7:0]};
  endfunction : merged

  // ==========
  // main sequence
  initial begin
    seed = 77518;
    errors = 0;
    checked = 0;
    cycles = 0;
    {wr, size_field, use_implied, ext_wr_en, ext_hi, ext_sel, ext_wdata, rd_sel, bit_num} = '0;
    {ea_req, flags_we, flags_in, sr_wr_en, sr_wdata, user_stack_ptr_wr_en, priv_op} = '0;
    {pc_load, pc_wdata, pc_step, exp_rd, exp_sf, user_stack_ptr_wdata} = '0;
    size_implied = crm_pkg::SZ_LONG;
    rf = '{default: '0};
    rst_chk(6);
    // random writes of bcd, byte, word and long sizes, read back one cycle behind
    wr.en = 1'b1;
    for (i = 0; i < 300; i++) begin
      check(rd_data, exp_rd);
      check(rd_bit, exp_rd[bit_num]);
      check(size_fault, exp_sf);
      {use_implied, wr.sel, bit_num, rd_sel, size_field} = 16'($random(seed));
      wr.data = $random(seed);
      size_implied = crm_pkg::crm_size_e'(5'h02 << size_field);
      sz = use_implied ? size_field - (size_field != 2'h0) : size_field - (size_field == 2'h3);
      exp_rd = rf[rd_sel];
      exp_sf = wr.sel[3] && sz == 2'h0;
      rf[wr.sel] = merged(rf[wr.sel], wr.data, wr.sel[3], sz);
      tick();
    end
    wr.en = 1'b0;
    // long register built from two halves on the narrow path
    {ext_wr_en, ext_sel, ext_hi, ext_wdata} = {1'b1, 4'h3, 1'b1, 16'hbeef};
    tick();
    {ext_hi, ext_wdata} = {1'b0, 16'h1234};
    tick();
    {ext_wr_en, ext_hi, rd_sel} = {1'b0, 1'b1, 4'h3};
    tick();
    check(rd_data, 32'hbeef_1234);
    check(ext_rdata, 16'hbeef);
    // indexed address with a negative word index
    wreg(4'h9, 32'h0000_1000);
    wreg(4'h2, 32'hffff_fff0);
    ea_req = '{1'b1, 1'b0, 3'h1, 1'b1, 4'h2, 1'b0, 16'h0004};
    tick();
    check(ea_valid, 1'b1);
    check(ea_addr, 32'h0000_0ff4);
    ea_req.en = 1'b0;
    tick();
    check(ea_valid, 1'b0);
    // load beats step, then step, then pc relative
    {pc_load, pc_step, pc_wdata} = {2'h3, 32'h0000_0100};
    tick();
    pc_load = 1'b0;
    tick();
    check(pc, 32'h0000_0102);
    pc_step = 1'b0;
    ea_req = '{1'b1, 1'b1, 3'h0, 1'b0, 4'h0, 1'b0, 16'hfffe};
    tick();
    ea_req.en = 1'b0;
    check(ea_addr, 32'h0000_0100);
    // flags, user stack pointer and status in supervisor mode
    {flags_we, flags_in, user_stack_ptr_wr_en, rd_sel} = {1'b1, 5'h15, 1'b1, 4'hf};
    user_stack_ptr_wdata = 32'h0000_2000;
    tick();
    {flags_we, user_stack_ptr_wr_en, sr_wr_en, sr_wdata} = {2'h0, 1'b1, 16'hffff};
    check(sr, 16'h2715);
    check(rd_data, rf[15]);
    tick();
    check(sr, 16'ha71f);
    check({trace, int_mask}, 4'hf);
    check(user_stack_ptr_rdata, 32'h0000_2000);
    // drop to user mode
    sr_wdata = 16'h0000;
    tick();
    sr_wr_en = 1'b0;
    check(supervisor, 1'b0);
    tick();
    check(rd_data, 32'h0000_2000);
    check(user_stack_ptr_rdata, 32'h0000_0000);
    priv_op = 1'b1;
    tick();
    {priv_op, sr_wr_en, sr_wdata} = {2'h1, 16'h27aa};
    check(priv_fault, 1'b1);
    tick();
    sr_wr_en = 1'b0;
    check(sr, 16'h000a);
    check(priv_fault, 1'b1);
    rst_chk(2);
    wrap_up();
  end
endmodule : test_cpu_core_register_model
`default_nettype wire
